/* File: hdl/dfp_pkg.sv */
// Constants for the DMA FIFO port status and transaction counter block.
// Assumes a 32-bit APB master; printed offsets are word indices.
package dfp_pkg;
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_CTRL      = 8'h30;
    localparam logic [7:0]  IDX_STAT      = 8'h34;
    localparam logic [7:0]  IDX_LIMIT     = 8'h36;
    localparam logic [9:0]  ADDR_CTRL     = {IDX_CTRL, 2'b00};
    localparam logic [9:0]  ADDR_STAT     = {IDX_STAT, 2'b00};
    localparam logic [9:0]  ADDR_LIMIT    = {IDX_LIMIT, 2'b00};
    // Control register fields
    localparam int          CT_PIPE_LSB   = 0;
    localparam int          CT_DIR_IN     = 3;
    localparam int          CT_CONT       = 4;
    localparam int          CT_REBM       = 5;
    localparam int          CT_CDOWN      = 6;
    localparam int          CT_TZERO      = 8;
    localparam int          CT_TON        = 9;
    localparam int          CT_MPS_LSB    = 16;
    // Status register fields
    localparam int          ST_BUFFER_VALID_FLAG       = 15;
    localparam int          ST_BUFFER_CLEAR_STROBE       = 14;
    localparam int          ST_PORT_READY_FLAG       = 13;
    // Reset values and sizes
    localparam logic [15:0] LIMIT_RST     = 16'h0000;
    localparam logic [10:0] MPS_RST       = 11'h0200;
    localparam logic [10:0] BUF_BYTES     = 11'h0200;
    localparam logic [10:0] STEP_NARROW   = 11'h0001;
    localparam logic [10:0] STEP_WIDE     = 11'h0002;
endpackage

/* File: hdl/dfp_txn_counter.sv */
// OUT transaction counter: current count against an upper limit.
// Assumes increment and clear are one-cycle pulses in the CLK_IN domain.
`timescale 1ns/1ns
module dfp_txn_counter
    import dfp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Control
    input  wire logic        inc_in,
    input  wire logic        clr_in,
    input  wire logic [15:0] limit_in,
    // Status
    output logic      [15:0] count_out,
    output logic             hit_out
);
    logic [15:0] count_q;

    assign count_out = count_q;
    // Reaching the limit is seen on the increment itself
    assign hit_out   = inc_in && ((count_q + 16'h0001) == limit_in);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_q <= 16'h0000;
        end else if (clr_in || hit_out) begin
            count_q <= 16'h0000;                        // [RULE20]
        end else if (inc_in) begin
            count_q <= count_q + 16'h0001;              // [RULE19]
        end
    end
endmodule

/* File: hdl/dfp_port_status.sv */
// DMA FIFO port status, buffer clear, byte length and transaction counting.
// Assumes synchronous pipe-side and DMA strobes, APB master with 32-bit data.
// Behaviour
// RULE1: OUT full or continuous short sets valid
// RULE2: OUT packet count reaching limit sets valid
// RULE3: OUT non-continuous sets valid every packet
// RULE4: OUT empty clears valid unless read-end mode
// RULE5: IN write one to valid sends short
// RULE6: IN valid plus clear sends zero-length
// RULE7: IN continuous full buffer sets valid
// RULE8: IN non-continuous max packet sets valid
// RULE9: IN last-transfer pin sets valid
// RULE10: IN empty clears valid, zero writes ignored
// RULE11: Software never rewrites set IN valid
// RULE12: Clear accepted only while port ready
// RULE13: Port ready reports data port access
// RULE14: Count-down subtracts one or two per read
// RULE15: No count-down holds, clears, IN invalid
// RULE16: Software polls ready before reading length
// RULE17: Current count and limit, OUT only
// RULE18: Writes load limit, reads depend enable
// RULE19: Enabled counter increments per OUT transaction
// RULE20: Short, limit or clear zeroes count
// RULE21: Software sets NAK before programming limit
// RULE22: Software leaves limit alone while enabled
// RULE23: One pipe per port, software's duty
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module dfp_port_status
    import dfp_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [9:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Pipe side
    input  wire logic        RX_PKT_IN,
    input  wire logic        RX_SHORT_IN,
    input  wire logic [9:0]  RX_LEN_IN,
    input  wire logic        TX_DONE_IN,
    // DMA data port strobes
    input  wire logic        DMA_RD_IN,
    input  wire logic        DMA_WR_IN,
    input  wire logic        DMA_WIDE_IN,
    input  wire logic        DMA_LAST_IN,
    // Status and commands
    output logic             BUFFER_VALID_OUT,
    output logic             PORT_READY_OUT,
    output logic             SEND_SHORT_OUT,
    output logic             SEND_ZLP_OUT,
    output logic             BUFFER_CLEAR_OUT
);
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [2:0]  pipe_sel_q;
    logic        dir_in_q;
    logic        cont_q;
    logic        rebm_q;
    logic        cdown_q;
    logic        ton_q;
    logic [10:0] mps_q;
    logic [15:0] limit_q;
    logic [10:0] bytes_q;
    logic [10:0] bytes_d;
    logic [9:0]  dtln_q;
    logic [9:0]  dtln_d;
    logic        buffer_valid_flag_q;
    logic        buffer_valid_flag_d;
    logic        port_ready_flag_q;
    logic        short_q;
    logic        zlp_q;
    logic        clr_q;
    logic [31:0] rdata;
    logic        rsel_err;
    logic        acc;
    logic        st_wr;
    logic        buffer_clear_strobe_req;
    logic        buffer_valid_flag_wr1;
    logic        rd_ev;
    logic        wr_ev;
    logic [10:0] step;
    logic        rx_out;
    logic        set_out;
    logic        set_in;
    logic        clr_buffer_valid_flag;
    logic        txn_inc;
    logic        txn_clr;
    logic        txn_hit;
    logic [15:0] txn_count;

    // APB decode; a write takes effect only on the edge that completes it
    assign acc      = PSEL_IN && PENABLE_IN && pready_q;
    assign st_wr    = acc && PWRITE_IN && (PADDR_IN == ADDR_STAT);
    assign buffer_clear_strobe_req = st_wr && PWDATA_IN[ST_BUFFER_CLEAR_STROBE] && port_ready_flag_q;              // [RULE12]
    assign buffer_valid_flag_wr1 = st_wr && PWDATA_IN[ST_BUFFER_VALID_FLAG] && dir_in_q;            // [RULE5] [RULE10]

    // Data port strobes count only while the port is ready
    assign rd_ev    = DMA_RD_IN && port_ready_flag_q && !dir_in_q;                   // [RULE13]
    assign wr_ev    = DMA_WR_IN && port_ready_flag_q && dir_in_q;                    // [RULE13]
    assign step     = DMA_WIDE_IN ? STEP_WIDE : STEP_NARROW;
    assign rx_out   = RX_PKT_IN && !dir_in_q;

    // Transaction counter serves OUT pipes only
    assign txn_inc  = ton_q && rx_out;                                    // [RULE17] [RULE19]
    assign txn_clr  = (acc && PWRITE_IN && (PADDR_IN == ADDR_CTRL) && PWDATA_IN[CT_TZERO])
                      || (txn_inc && RX_SHORT_IN);                        // [RULE20]

    dfp_txn_counter u_txn (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .inc_in    (txn_inc),
        .clr_in    (txn_clr),
        .limit_in  (limit_q),
        .count_out (txn_count),
        .hit_out   (txn_hit)
    );

    // Buffer fill level
    always_comb begin
        bytes_d = bytes_q;
        if (buffer_clear_strobe_req) begin
            bytes_d = 11'h0000;
        end else begin
            if (rx_out) begin
                bytes_d = bytes_d + {1'b0, RX_LEN_IN};
            end
            if (rd_ev) begin
                bytes_d = (bytes_d > step) ? (bytes_d - step) : 11'h0000;
            end
            if (wr_ev) begin
                bytes_d = bytes_d + step;
            end
            if (dir_in_q && TX_DONE_IN) begin
                bytes_d = 11'h0000;
            end
        end
    end

    // Valid flag; a set in the same cycle as a clear wins
    assign set_out = rx_out && ((bytes_d >= BUF_BYTES)                    // [RULE1]
                     || (RX_SHORT_IN && cont_q)                           // [RULE1]
                     || txn_hit                                           // [RULE2]
                     || !cont_q);                                         // [RULE3]
    assign set_in  = buffer_valid_flag_wr1
                     || (wr_ev && cont_q && (bytes_d >= BUF_BYTES))       // [RULE7]
                     || (wr_ev && !cont_q && (bytes_d >= mps_q))          // [RULE8]
                     || (wr_ev && DMA_LAST_IN);                           // [RULE9]
    assign clr_buffer_valid_flag = buffer_clear_strobe_req
                      || (rd_ev && (bytes_d == 11'h0000) && !rebm_q)      // [RULE4]
                      || (dir_in_q && TX_DONE_IN);                        // [RULE10]

    always_comb begin
        buffer_valid_flag_d = buffer_valid_flag_q;
        if (clr_buffer_valid_flag) begin
            buffer_valid_flag_d = 1'b0;
        end
        if (set_out || set_in) begin
            buffer_valid_flag_d = 1'b1;
        end
    end

    // Received byte length
    always_comb begin
        dtln_d = dtln_q;
        if (buffer_clear_strobe_req || dir_in_q) begin
            dtln_d = 10'h000;                                             // [RULE15]
        end else if (rx_out) begin
            dtln_d = RX_LEN_IN;
        end else if (rd_ev && cdown_q) begin
            dtln_d = (dtln_q > step[9:0]) ? (dtln_q - step[9:0]) : 10'h000; // [RULE14]
        end else if (rd_ev && (bytes_d == 11'h0000)) begin
            dtln_d = 10'h000;                                             // [RULE15]
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            bytes_q <= 11'h0000;
            buffer_valid_flag_q  <= 1'b0;
            dtln_q  <= 10'h000;
        end else begin
            bytes_q <= bytes_d;
            buffer_valid_flag_q  <= buffer_valid_flag_d;
            dtln_q  <= dtln_d;
        end
    end

    // Ready: OUT needs data present, IN needs room; no pipe means never ready
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            port_ready_flag_q <= 1'b0;
        end else begin
            port_ready_flag_q <= (pipe_sel_q != 3'h0) && (dir_in_q ? !buffer_valid_flag_d : buffer_valid_flag_d); // [RULE13]
        end
    end

    // Command pulses toward the pipe engine
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            short_q <= 1'b0;
            zlp_q   <= 1'b0;
            clr_q   <= 1'b0;
        end else begin
            short_q <= buffer_valid_flag_wr1 && !PWDATA_IN[ST_BUFFER_CLEAR_STROBE];                   // [RULE5]
            zlp_q   <= buffer_valid_flag_wr1 && PWDATA_IN[ST_BUFFER_CLEAR_STROBE];                    // [RULE6]
            clr_q   <= buffer_clear_strobe_req;                                          // [RULE12]
        end
    end

    // Control and limit registers
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            pipe_sel_q <= 3'h0;
            dir_in_q   <= 1'b0;
            cont_q     <= 1'b0;
            rebm_q     <= 1'b0;
            cdown_q    <= 1'b0;
            ton_q      <= 1'b0;
            mps_q      <= MPS_RST;
            limit_q    <= LIMIT_RST;
        end else if (acc && PWRITE_IN) begin
            if (PADDR_IN == ADDR_CTRL) begin
                pipe_sel_q <= PWDATA_IN[CT_PIPE_LSB +: 3];
                dir_in_q   <= PWDATA_IN[CT_DIR_IN];
                cont_q     <= PWDATA_IN[CT_CONT];
                rebm_q     <= PWDATA_IN[CT_REBM];
                cdown_q    <= PWDATA_IN[CT_CDOWN];
                ton_q      <= PWDATA_IN[CT_TON];
                mps_q      <= PWDATA_IN[CT_MPS_LSB +: 11];
            end
            if (PADDR_IN == ADDR_LIMIT) begin
                limit_q <= PWDATA_IN[15:0];                               // [RULE18]
            end
        end
    end

    // Read mux; the clear bit always reads zero
    always_comb begin
        rdata    = 32'h0000_0000;
        rsel_err = 1'b0;
        case (PADDR_IN)
            ADDR_CTRL: begin
                rdata[CT_PIPE_LSB +: 3] = pipe_sel_q;
                rdata[CT_DIR_IN]        = dir_in_q;
                rdata[CT_CONT]          = cont_q;
                rdata[CT_REBM]          = rebm_q;
                rdata[CT_CDOWN]         = cdown_q;
                rdata[CT_TON]           = ton_q;
                rdata[CT_MPS_LSB +: 11] = mps_q;
            end
            ADDR_STAT: begin
                rdata[ST_BUFFER_VALID_FLAG] = buffer_valid_flag_q;
                rdata[ST_PORT_READY_FLAG] = port_ready_flag_q;
                rdata[9:0]     = dtln_q;
            end
            ADDR_LIMIT: begin
                rdata[15:0] = ton_q ? txn_count : limit_q;                // [RULE18]
            end
            default: begin
                rsel_err = 1'b1;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (PSEL_IN && PENABLE_IN && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= rsel_err;
            prdata_q  <= PWRITE_IN ? 32'h0000_0000 : rdata;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign PRDATA_OUT       = prdata_q;
    assign PREADY_OUT       = pready_q;
    assign PSLVERR_OUT      = pslverr_q;
    assign BUFFER_VALID_OUT = buffer_valid_flag_q;
    assign PORT_READY_OUT   = port_ready_flag_q;
    assign SEND_SHORT_OUT   = short_q;
    assign SEND_ZLP_OUT     = zlp_q;
    assign BUFFER_CLEAR_OUT = clr_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_out_nc_set: assert property (rx_out && !cont_q |=> BUFFER_VALID_OUT) // [RULE3]
        else $error("OUT packet in non-continuous mode did not set valid");

    a_out_empty_clr: assert property (                                  // [RULE4]
        rd_ev && !rx_out && !rebm_q && (bytes_d == 11'h0000) |=> !BUFFER_VALID_OUT)
        else $error("Valid stayed set after OUT buffer emptied");

    a_in_short_cmd: assert property (                                   // [RULE5]
        st_wr && dir_in_q && PWDATA_IN[ST_BUFFER_VALID_FLAG] && !PWDATA_IN[ST_BUFFER_CLEAR_STROBE]
        |=> SEND_SHORT_OUT && BUFFER_VALID_OUT ##1 !SEND_SHORT_OUT)
        else $error("Short packet command missing or not a single pulse");

    a_in_zlp_cmd: assert property (                                     // [RULE6]
        st_wr && dir_in_q && PWDATA_IN[ST_BUFFER_VALID_FLAG] && PWDATA_IN[ST_BUFFER_CLEAR_STROBE]
        |=> SEND_ZLP_OUT && !SEND_SHORT_OUT)
        else $error("Zero-length packet command missing");

    a_dma_last_transfer_pin_set: assert property (wr_ev && DMA_LAST_IN |=> BUFFER_VALID_OUT) // [RULE9]
        else $error("Last-transfer pin did not set valid");

    a_buffer_clear_strobe_refused: assert property (                                   // [RULE12]
        st_wr && PWDATA_IN[ST_BUFFER_CLEAR_STROBE] && !PORT_READY_OUT |=> !BUFFER_CLEAR_OUT)
        else $error("Buffer clear accepted while port not ready");

    a_cnt_down: assert property (                                       // [RULE14]
        rd_ev && cdown_q && !buffer_clear_strobe_req && !rx_out && DMA_WIDE_IN && (dtln_q > 10'h002)
        |=> dtln_q == $past(dtln_q) - 10'h002)
        else $error("Byte length did not count down by two");

    a_txn_inc: assert property (                                        // [RULE19]
        txn_inc && !txn_hit && !txn_clr |=> txn_count == $past(txn_count) + 16'h0001)
        else $error("Transaction count did not advance");

    a_txn_limit: assert property (                                      // [RULE2]
        txn_inc && txn_hit |=> BUFFER_VALID_OUT && (txn_count == 16'h0000))
        else $error("Reaching limit did not set valid and clear count");

    a_in_len_zero: assert property (dir_in_q |=> dtln_q == 10'h000)      // [RULE15]
        else $error("Byte length not zero for IN pipe");

    c_short_pkt: cover property (SEND_SHORT_OUT);
    c_zlp_pkt: cover property (SEND_ZLP_OUT);
    c_txn_hit: cover property (txn_inc && txn_hit);
    c_clear_acc: cover property (BUFFER_CLEAR_OUT);
endmodule

/* File: bench/dfp_far_side.sv */
// Far side model: USB engine pulses and an external DMA controller.
// Assumes the block samples every strobe on the rising clock edge.
`timescale 1ns/1ns
module dfp_far_side (
    // Clock and port status
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    // Pipe side
    output logic            rx_pkt_out,
    output logic            rx_short_out,
    output logic [9:0]      rx_len_out,
    output logic            tx_done_out,
    // DMA strobes
    output logic            dma_rd_out,
    output logic            dma_wr_out,
    output logic            dma_wide_out,
    output logic            dma_last_out
);
    // Idle cycles after each packet and DMA access, to play a slow partner
    int pause = 0;
    initial begin
        {rx_pkt_out, rx_short_out, tx_done_out} = 3'b000;
        {dma_rd_out, dma_wr_out, dma_wide_out, dma_last_out} = 4'b0000;
        rx_len_out = 10'h000;
    end
    task automatic pkt(input logic [9:0] len, input logic short);
        @(posedge clk_in);
        rx_pkt_out <= 1'b1;
        rx_short_out <= short;
        rx_len_out <= len;
        @(posedge clk_in);
        rx_pkt_out <= 1'b0;
        rx_short_out <= 1'b0;
        // Length is only qualified by the pulse, so it must not linger
        rx_len_out <= ~len;
        repeat (pause) @(posedge clk_in);
    endtask
    task automatic done();
        @(posedge clk_in);
        tx_done_out <= 1'b1;
        @(posedge clk_in);
        tx_done_out <= 1'b0;
    endtask
    task automatic access(input logic wr, input logic wide, input logic last);
        @(posedge clk_in);
        if (ready_in === 1'b1) begin
            dma_rd_out <= ~wr;
            dma_wr_out <= wr;
            dma_wide_out <= wide;
            dma_last_out <= last;
        end
        @(posedge clk_in);
        dma_rd_out <= 1'b0;
        dma_wr_out <= 1'b0;
        dma_wide_out <= ~wide;
        dma_last_out <= 1'b0;
        repeat (pause) @(posedge clk_in);
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the DMA FIFO port status block.
// Assumes one APB master here and the far side model in dfp_far_side.
`timescale 1ns/1ns
module testbench;
    import dfp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, rx_pkt, rx_short, tx_done;
    logic [9:0]  rx_len;
    logic        dma_rd, dma_wr, dma_wide, dma_last;
    logic        valid, ready, snd_short, snd_zlp, buffer_clear_strobe;
    logic [31:0] r;
    logic        e;
    int          num_errors = 0;
    int          checks_done = 0;
    int          n_short = 0;
    int          n_zlp = 0;
    int          n_clr = 0;
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        if (snd_short === 1'b1) n_short <= n_short + 1;
        if (snd_zlp === 1'b1) n_zlp <= n_zlp + 1;
        if (buffer_clear_strobe === 1'b1) n_clr <= n_clr + 1;
    end
    dfp_port_status dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RX_PKT_IN(rx_pkt), .RX_SHORT_IN(rx_short),
        .RX_LEN_IN(rx_len), .TX_DONE_IN(tx_done), .DMA_RD_IN(dma_rd), .DMA_WR_IN(dma_wr),
        .DMA_WIDE_IN(dma_wide), .DMA_LAST_IN(dma_last), .BUFFER_VALID_OUT(valid),
        .PORT_READY_OUT(ready), .SEND_SHORT_OUT(snd_short), .SEND_ZLP_OUT(snd_zlp),
        .BUFFER_CLEAR_OUT(buffer_clear_strobe));
    dfp_far_side far (.clk_in(clk), .ready_in(ready), .rx_pkt_out(rx_pkt), .rx_short_out(rx_short),
        .rx_len_out(rx_len), .tx_done_out(tx_done), .dma_rd_out(dma_rd), .dma_wr_out(dma_wr),
        .dma_wide_out(dma_wide), .dma_last_out(dma_last));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_val(r, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc(ADDR_LIMIT, 32'h0000_0000);
        rdc(ADDR_STAT, 32'h0000_0000);
        apb(1'b0, 10'h3FC, 32'h0000_0000);
        chk_bit(e, 1'b1);
        $display("test reset and map done");
        // Only pipe 1 is ever given to this port
        wr(ADDR_CTRL, 32'h0000_0041);
        far.pkt(10'h004, 1'b0);
        idle(2);
        chk_bit(valid, 1'b1);
        chk_bit(ready, 1'b1);
        far.access(1'b0, 1'b1, 1'b0);
        rdc(ADDR_STAT, 32'h0000_A002);
        far.access(1'b0, 1'b0, 1'b0);
        rdc(ADDR_STAT, 32'h0000_A001);
        far.access(1'b0, 1'b0, 1'b0);
        idle(2);
        chk_bit(valid, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0001);
        far.pkt(10'h004, 1'b0);
        far.access(1'b0, 1'b0, 1'b0);
        rdc(ADDR_STAT, 32'h0000_A004);
        far.access(1'b0, 1'b1, 1'b0);
        far.access(1'b0, 1'b0, 1'b0);
        idle(3);
        rdc(ADDR_STAT, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0021);
        far.pkt(10'h002, 1'b0);
        far.access(1'b0, 1'b1, 1'b0);
        idle(3);
        chk_bit(valid, 1'b1);
        wr(ADDR_STAT, 32'h0000_4000);
        idle(2);
        chk_bit(valid, 1'b0);
        idle(2);
        wr(ADDR_STAT, 32'h0000_4000);
        idle(2);
        chk_val(32'(n_clr), 32'h0000_0001);
        $display("test out pipe done");
        // Limit only changes with the counter off and traffic stopped
        wr(ADDR_CTRL, 32'h0000_0011);
        wr(ADDR_LIMIT, 32'h0000_0002);
        rdc(ADDR_LIMIT, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0211);
        far.pkt(10'h008, 1'b0);
        idle(2);
        chk_bit(valid, 1'b0);
        rdc(ADDR_LIMIT, 32'h0000_0001);
        far.pkt(10'h008, 1'b0);
        idle(2);
        chk_bit(valid, 1'b1);
        rdc(ADDR_LIMIT, 32'h0000_0000);
        wr(ADDR_STAT, 32'h0000_4000);
        far.pause = 2;
        far.pkt(10'h008, 1'b0);
        rdc(ADDR_LIMIT, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0311);
        rdc(ADDR_LIMIT, 32'h0000_0000);
        // Count is zero here, so only the short packet can keep it there
        far.pkt(10'h003, 1'b1);
        chk_bit(valid, 1'b1);
        rdc(ADDR_LIMIT, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0011);
        rdc(ADDR_LIMIT, 32'h0000_0002);
        wr(ADDR_STAT, 32'h0000_4000);
        $display("test counter done");
        wr(ADDR_CTRL, 32'h0004_0009);
        idle(2);
        chk_bit(ready, 1'b1);
        wr(ADDR_STAT, 32'h0000_8000);
        idle(2);
        chk_bit(valid, 1'b1);
        chk_val(32'(n_short), 32'h0000_0001);
        rdc(ADDR_STAT, 32'h0000_8000);
        wr(ADDR_STAT, 32'h0000_0000);
        idle(2);
        chk_bit(valid, 1'b1);
        // Valid is let go before it is written again
        far.done();
        idle(2);
        chk_bit(valid, 1'b0);
        wr(ADDR_STAT, 32'h0000_C000);
        idle(2);
        chk_val(32'(n_zlp), 32'h0000_0001);
        far.done();
        far.access(1'b1, 1'b1, 1'b0);
        far.access(1'b1, 1'b1, 1'b0);
        chk_bit(valid, 1'b1);
        far.done();
        far.access(1'b1, 1'b0, 1'b1);
        chk_bit(valid, 1'b1);
        far.done();
        far.pause = 0;
        wr(ADDR_CTRL, 32'h0004_0019);
        repeat (255) far.access(1'b1, 1'b1, 1'b0);
        idle(2);
        chk_bit(valid, 1'b0);
        far.access(1'b1, 1'b1, 1'b0);
        idle(2);
        chk_bit(valid, 1'b1);
        $display("test in pipe done");
        tally_and_finish();
    end
endmodule
